// ### rtl/spw_regs.svh
// Behaviour
// - Vertical sync is active low by default and is inverted when polarity bit 2 is one.
// - Horizontal blanking is low during active samples and high elsewhere, inverted by bit 1.
// - Horizontal sync is active low by default and is inverted when polarity bit 0 is one.
// - The custom horizontal pulse starts at the pixel held in the 16-bit horizontal begin register.
// - The custom horizontal pulse ends at the pixel held in the 16-bit horizontal finish register.
// - The custom vertical pulse starts on the line in the 15-bit vertical begin field.
// - The custom vertical pulse ends on the line in the 15-bit vertical finish field.
// - Horizontal and vertical pulses combine by AND, else OR, else XOR by operator bits.
// - The combined custom output is active low while its invert bit is one, its reset value.
`ifndef SPW_REGS_SVH
`define SPW_REGS_SVH
`define SPW_IDX_POL 7'h56
`define SPW_IDX_HBEG 7'h57
`define SPW_IDX_HFIN 7'h58
`define SPW_IDX_VBEG 7'h59
`define SPW_IDX_VFIN 7'h5A
`define SPW_IDX_OPER 7'h5B
`define SPW_POL_VS 2
`define SPW_POL_HB 1
`define SPW_POL_HS 0
`define SPW_OP_INV 3
`define SPW_OP_AND 2
`define SPW_OP_OR 1
`define SPW_OP_XOR 0
`define SPW_VLINE_W 15
`define SPW_RST_ZERO 16'h0000
`define SPW_RST_OPER 16'h0008
`define SPW_POL_MASK 16'h03BF
`define SPW_OPER_MASK 16'h000F
`define SPW_VMASK 16'h7FFF
`endif

// ### rtl/spw_pkg.sv
package spw_pkg;
    typedef logic [15:0] spw_word_t;
    typedef enum logic [1:0] {
        SPW_IDLE = 2'b00,
        SPW_RESP = 2'b01
    } spw_bus_e;
endpackage

// ### rtl/spw_range.sv
`timescale 1ns/1ps
module spw_range #(
    parameter int W = 16
) (
    // clocking
    input wire logic clk,
    input wire logic rst,
    // compare
    input wire logic [W-1:0] count,
    input wire logic [W-1:0] first,
    input wire logic [W-1:0] last,
    input wire logic step,
    // result
    output logic active
);
    logic next_active;

    always_comb begin
        next_active = active;
        if (step) begin
            next_active = (count >= first) && (count <= last);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            active <= 1'b0;
        end else begin
            active <= next_active;
        end
    end
endmodule

// ### rtl/spw_top.sv
`timescale 1ns/1ps
`include "spw_regs.svh"
module spw_top
    import spw_pkg::*;
#(
    parameter int PIX_W = 16,
    parameter int LINE_W = 15
) (
    // clocking
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave, word addressed
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // raw timing from the counters, same clock
    input wire logic [PIX_W-1:0] pixel_count,
    input wire logic [LINE_W-1:0] line_count,
    input wire logic pixel_step,
    input wire logic hsync_raw,
    input wire logic hactive_raw,
    input wire logic vsync_raw,
    // timing outputs
    output logic hsync_out,
    output logic hblank_out,
    output logic vsync_out,
    output logic custom_a_horiz_pulse,
    output logic custom_a_vert_pulse,
    output logic custom_a_out
);
    spw_word_t output_polarity_control, next_pol;
    spw_word_t custom_a_horiz_begin, next_hbeg;
    spw_word_t custom_a_horiz_finish, next_hfin;
    spw_word_t custom_a_vert_begin, next_vbeg;
    spw_word_t custom_a_vert_finish, next_vfin;
    spw_word_t custom_a_operator, next_oper;
    spw_bus_e bus_state, next_bus_state;
    logic [31:0] next_readdata;
    logic next_hsync, next_hblank, next_vsync, next_custom;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic comb_h;

    // one wait cycle on every access keeps readdata registered
    assign avs_waitrequest = (avs_read || avs_write) && (bus_state == SPW_IDLE);
    assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wdata = avs_writedata[15:0];

    always_comb begin
        next_bus_state = SPW_IDLE;
        next_pol = output_polarity_control;
        next_hbeg = custom_a_horiz_begin;
        next_hfin = custom_a_horiz_finish;
        next_vbeg = custom_a_vert_begin;
        next_vfin = custom_a_vert_finish;
        next_oper = custom_a_operator;
        next_readdata = avs_readdata;
        if ((avs_read || avs_write) && bus_state == SPW_IDLE) begin
            next_bus_state = SPW_RESP;
        end
        if (avs_write && bus_state == SPW_RESP) begin
            case (avs_address)
                `SPW_IDX_POL: begin
                    next_pol = ((output_polarity_control & ~wmask) | (wdata & wmask))
                        & `SPW_POL_MASK;
                end
                `SPW_IDX_HBEG: begin
                    next_hbeg = (custom_a_horiz_begin & ~wmask) | (wdata & wmask);
                end
                `SPW_IDX_HFIN: begin
                    next_hfin = (custom_a_horiz_finish & ~wmask) | (wdata & wmask);
                end
                `SPW_IDX_VBEG: begin
                    // reserved top bit is dropped whatever software sends
                    next_vbeg = ((custom_a_vert_begin & ~wmask) | (wdata & wmask))
                        & `SPW_VMASK;
                end
                `SPW_IDX_VFIN: begin
                    next_vfin = ((custom_a_vert_finish & ~wmask) | (wdata & wmask))
                        & `SPW_VMASK;
                end
                `SPW_IDX_OPER: begin
                    next_oper = ((custom_a_operator & ~wmask) | (wdata & wmask))
                        & `SPW_OPER_MASK;
                end
                default: begin
                end
            endcase
        end
        if (avs_read && bus_state == SPW_IDLE) begin
            case (avs_address)
                `SPW_IDX_POL: next_readdata = {16'h0000, output_polarity_control};
                `SPW_IDX_HBEG: next_readdata = {16'h0000, custom_a_horiz_begin};
                `SPW_IDX_HFIN: next_readdata = {16'h0000, custom_a_horiz_finish};
                `SPW_IDX_VBEG: next_readdata = {16'h0000, custom_a_vert_begin};
                `SPW_IDX_VFIN: next_readdata = {16'h0000, custom_a_vert_finish};
                `SPW_IDX_OPER: next_readdata = {16'h0000, custom_a_operator};
                default: next_readdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_state <= SPW_IDLE;
            output_polarity_control <= `SPW_RST_ZERO;
            custom_a_horiz_begin <= `SPW_RST_ZERO;
            custom_a_horiz_finish <= `SPW_RST_ZERO;
            custom_a_vert_begin <= `SPW_RST_ZERO;
            custom_a_vert_finish <= `SPW_RST_ZERO;
            custom_a_operator <= `SPW_RST_OPER;
            avs_readdata <= 32'h00000000;
        end else begin
            bus_state <= next_bus_state;
            output_polarity_control <= next_pol;
            custom_a_horiz_begin <= next_hbeg;
            custom_a_horiz_finish <= next_hfin;
            custom_a_vert_begin <= next_vbeg;
            custom_a_vert_finish <= next_vfin;
            custom_a_operator <= next_oper;
            avs_readdata <= next_readdata;
        end
    end

    // window pulses, both registered one cycle behind the counters
    spw_range #(.W(PIX_W)) u_hwin (
        .clk(clk),
        .rst(rst),
        .count(pixel_count),
        .first(custom_a_horiz_begin[PIX_W-1:0]),
        .last(custom_a_horiz_finish[PIX_W-1:0]),
        .step(pixel_step),
        .active(custom_a_horiz_pulse)
    );

    spw_range #(.W(LINE_W)) u_vwin (
        .clk(clk),
        .rst(rst),
        .count(line_count),
        .first(custom_a_vert_begin[LINE_W-1:0]),
        .last(custom_a_vert_finish[LINE_W-1:0]),
        .step(pixel_step),
        .active(custom_a_vert_pulse)
    );

    always_comb begin
        next_hsync = ~hsync_raw ^ output_polarity_control[`SPW_POL_HS];
        next_hblank = ~hactive_raw ^ output_polarity_control[`SPW_POL_HB];
        next_vsync = ~vsync_raw ^ output_polarity_control[`SPW_POL_VS];
        if (custom_a_operator[`SPW_OP_AND]) begin
            comb_h = custom_a_horiz_pulse & custom_a_vert_pulse;
        end else if (custom_a_operator[`SPW_OP_OR]) begin
            comb_h = custom_a_horiz_pulse | custom_a_vert_pulse;
        end else if (custom_a_operator[`SPW_OP_XOR]) begin
            comb_h = custom_a_horiz_pulse ^ custom_a_vert_pulse;
        end else begin
            comb_h = 1'b0;
        end
        next_custom = comb_h ^ custom_a_operator[`SPW_OP_INV];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hsync_out <= 1'b1;
            hblank_out <= 1'b1;
            vsync_out <= 1'b1;
            custom_a_out <= 1'b1;
        end else begin
            hsync_out <= next_hsync;
            hblank_out <= next_hblank;
            vsync_out <= next_vsync;
            custom_a_out <= next_custom;
        end
    end

    // sync, blank and custom outputs leave reset idle high, so the first edge after release is skipped
    a_hsync_pol: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> hsync_out
        == ($past(~hsync_raw) ^ $past(output_polarity_control[`SPW_POL_HS])))
        else $error("hsync polarity wrong");
    a_hblank_pol: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> hblank_out
        == ($past(~hactive_raw) ^ $past(output_polarity_control[`SPW_POL_HB])))
        else $error("hblank polarity wrong");
    a_vsync_pol: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> vsync_out
        == ($past(~vsync_raw) ^ $past(output_polarity_control[`SPW_POL_VS])))
        else $error("vsync polarity wrong");
    a_hwin_begin: assert property (@(posedge clk) disable iff (rst)
        pixel_step && pixel_count == custom_a_horiz_begin && pixel_count <= custom_a_horiz_finish
        |=> custom_a_horiz_pulse)
        else $error("horizontal pulse missed its begin");
    a_hwin_finish: assert property (@(posedge clk) disable iff (rst)
        pixel_step && pixel_count == custom_a_horiz_finish + 16'h0001 |=> !custom_a_horiz_pulse)
        else $error("horizontal pulse ran past its finish");
    a_vwin_begin: assert property (@(posedge clk) disable iff (rst)
        pixel_step && line_count == custom_a_vert_begin[14:0]
        && line_count <= custom_a_vert_finish[14:0] |=> custom_a_vert_pulse)
        else $error("vertical pulse missed its begin");
    a_vwin_finish: assert property (@(posedge clk) disable iff (rst)
        pixel_step && line_count > custom_a_vert_finish[14:0] |=> !custom_a_vert_pulse)
        else $error("vertical pulse ran past its finish");
    a_hwin_hold: assert property (@(posedge clk) disable iff (rst)
        !pixel_step |=> $stable(custom_a_horiz_pulse))
        else $error("horizontal pulse moved without a pixel step");
    a_custom_and: assert property (@(posedge clk) disable iff (rst)
        custom_a_operator[`SPW_OP_AND]
        |=> custom_a_out == ($past(custom_a_horiz_pulse & custom_a_vert_pulse)
        ^ $past(custom_a_operator[`SPW_OP_INV])))
        else $error("and combination wrong");
    a_custom_idle: assert property (@(posedge clk) disable iff (rst)
        custom_a_operator[3:0] == 4'h8 |=> custom_a_out)
        else $error("custom output not idle high");
    c_hpulse: cover property (@(posedge clk) $rose(custom_a_horiz_pulse));
    c_vpulse: cover property (@(posedge clk) $rose(custom_a_vert_pulse));
    c_custom: cover property (@(posedge clk) $fell(custom_a_out));
endmodule

// ### verification/spw_timing_model.sv
`timescale 1ns/1ps
module spw_timing_model #(
    parameter int PIX_TOT = 16,
    parameter int LINE_TOT = 5
) (
    // clocking
    input wire logic clk,
    input wire logic rst,
    // pixel enable hold-off from the bench
    input wire logic stall,
    // raw timing
    output logic [15:0] pixel_count,
    output logic [14:0] line_count,
    output logic pixel_step,
    output logic hsync_raw,
    output logic hactive_raw,
    output logic vsync_raw
);
    // tiny line and field keep a frame to a few dozen cycles
    // counters only move on a pixel step, so a stall freezes the whole raster
    always @(posedge clk) begin
        if (rst) begin
            pixel_count <= 16'h0000;
            line_count <= 15'h0000;
        end else if (pixel_step) begin
            if (pixel_count == 16'(PIX_TOT - 1)) begin
                pixel_count <= 16'h0000;
                line_count <= (line_count == 15'(LINE_TOT - 1)) ? 15'h0000 : line_count + 15'h1;
            end else begin
                pixel_count <= pixel_count + 16'h0001;
            end
        end
    end
    assign pixel_step = !stall;
    assign hsync_raw = pixel_count < 16'h0002;
    assign hactive_raw = pixel_count >= 16'h0004 && pixel_count < 16'h000E;
    assign vsync_raw = line_count == 15'h0000;
endmodule

// ### verification/sync_polarity_and_user_window_bench.sv
`timescale 1ns/1ps
module sync_polarity_and_user_window_bench;
    import spw_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] avs_address = 7'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h3;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] pixel_count;
    logic [14:0] line_count;
    logic pixel_step, hsync_raw, hactive_raw, vsync_raw;
    logic stall = 1'b0;
    logic hsync_out, hblank_out, vsync_out, hp_out, vp_out, cust_out;
    int n_fail = 0;
    int n_compared = 0;
    int m;
    spw_word_t q, pol, oper;
    localparam spw_word_t HB = 16'h0003, HF = 16'h0009, VB = 16'h0001, VF = 16'h0003;
    spw_word_t modes [8] = '{16'h0008, 16'h000E, 16'h000B, 16'h0009,
                             16'h0004, 16'h0003, 16'h0001, 16'h0000};
    always #2 clk = ~clk;
    spw_timing_model model (.clk(clk), .rst(rst), .stall(stall), .pixel_count(pixel_count),
        .line_count(line_count), .pixel_step(pixel_step), .hsync_raw(hsync_raw),
        .hactive_raw(hactive_raw), .vsync_raw(vsync_raw));
    spw_top dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pixel_count(pixel_count), .line_count(line_count), .pixel_step(pixel_step),
        .hsync_raw(hsync_raw), .hactive_raw(hactive_raw), .vsync_raw(vsync_raw),
        .hsync_out(hsync_out), .hblank_out(hblank_out), .vsync_out(vsync_out),
        .custom_a_horiz_pulse(hp_out), .custom_a_vert_pulse(vp_out), .custom_a_out(cust_out));
    task automatic finish_test();
        $display("compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input spw_word_t seen, input spw_word_t exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // a clock edge passes before each request so strobes never toggle twice in one step
    task automatic xfer(input logic w, input logic [6:0] a, input spw_word_t d,
                        input logic [3:0] be);
        int i;
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        // waitrequest and readdata are taken at the edge that ends the cycle
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) begin
            n_fail++;
            finish_test();
        end
        q = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [6:0] a, input spw_word_t d);
        xfer(1'b1, a, d, 4'h3);
    endtask
    task automatic rd(input logic [6:0] a, input spw_word_t exp);
        xfer(1'b0, a, 16'h0000, 4'h3);
        chk(q, exp);
    endtask
    // combined output lags the pulses by one more register stage
    task automatic watch(input int n);
        logic [4:0] e;
        logic h, v, ph, pv, c;
        int k;
        for (k = 0; k < n; k++) begin
            @(posedge clk);
            // stall only from the third cycle, so the first expectation is stepped
            stall <= (m == 5) && k[1];
            #1;
            if (k > 1) begin
                chk(hsync_out, e[0]);
                chk(hblank_out, e[1]);
                chk(vsync_out, e[2]);
                chk(hp_out, e[3]);
                chk(vp_out, e[4]);
                chk(cust_out, c ^ oper[3]);
            end
            c = oper[2] ? ph & pv : oper[1] ? ph | pv : oper[0] & (ph ^ pv);
            if (pixel_step) begin
                h = (HB <= pixel_count) && (pixel_count <= HF);
                v = (VB <= {1'b0, line_count}) && ({1'b0, line_count} <= VF);
            end
            e = {v, h, ~vsync_raw ^ pol[2], ~hactive_raw ^ pol[1], ~hsync_raw ^ pol[0]};
            ph = h;
            pv = v;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (m = 0; m < 6; m++) rd(7'h56 + 7'(m), m == 5 ? 16'h0008 : 16'h0000);
        wr(7'h10, 16'hFFFF);
        rd(7'h10, 16'h0000);
        wr(7'h56, 16'hFFFF);
        rd(7'h56, 16'h03BF);
        wr(7'h59, 16'hFFFF);
        rd(7'h59, 16'h7FFF);
        wr(7'h5A, 16'hFFFF);
        rd(7'h5A, 16'h7FFF);
        wr(7'h5B, 16'hFFFF);
        rd(7'h5B, 16'h000F);
        xfer(1'b1, 7'h57, 16'hABCD, 4'h1);
        rd(7'h57, 16'h00CD);
        xfer(1'b1, 7'h57, 16'h1234, 4'h2);
        rd(7'h57, 16'h12CD);
        $display("register test done");
        wr(7'h57, HB);
        wr(7'h58, HF);
        wr(7'h59, VB);
        wr(7'h5A, VF);
        for (m = 0; m < 8; m++) begin
            pol = 16'(m);
            oper = modes[m];
            wr(7'h56, pol);
            wr(7'h5B, oper);
            watch(160);
            $display("timing test %0d done", m);
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(7'h57, 16'h0000);
        rd(7'h5B, 16'h0008);
        $display("second reset test done");
        finish_test();
    end
endmodule
